// [hw/palc_pkg.sv]
// What this block does
// - serial activity data out; frame strobe out only when standalone
// - each sample period spans at most ten bit times
// - short carrier pulses latched until next sample
// - collision slot low standalone, else follows AUI collision
// - loopback echoes each receive to its transmits
// - only squelch-qualified receive data echoed
// - echo is unretimed, passes straight through
// - minimum mode never enters loopback
// - test pin low leaves loopback at once
// - test high during reset selects minimum mode
package palc_pkg;
  localparam int CLK_MHZ = 125;
  // one bit time at 10 Mb/s, in ns
  localparam int BIT_TIME_NS = 100;
  localparam int BIT_TIME_UNITS_PER_SAMPLE = 10;
  localparam int SAMPLE_NS = BIT_TIME_NS * BIT_TIME_UNITS_PER_SAMPLE;
  // longest time: round down
  localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ) / 1000;
  localparam int NUM_SLOTS = 10;
  localparam int SLOT_CYC = SAMPLE_CYC / NUM_SLOTS;
  localparam int NUM_TP = 8;
  localparam logic [1:0] ZEROS_TO_LOOP = 2'h3;
  localparam logic [3:0] SLOT_COLL = 4'h0;
  localparam logic [3:0] SLOT_AUI = 4'h1;
  localparam logic [3:0] SLOT_LAST = 4'h9;
  localparam logic [7:0] SLOT_CYC_LAST = 8'(SLOT_CYC - 1);
endpackage

// [hw/palc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module palc_sync import palc_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  // no reset: keeps sampling through reset so the mode strap is seen at release
  always_ff @(posedge clock_i) begin
    meta_q <= async_i;
    sync_o <= meta_q;
  end
endmodule
`default_nettype wire

// [hw/palc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module palc_top import palc_pkg::*; (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [NUM_TP-1:0] tp_crs_i,
  input wire logic aui_crs_i,
  input wire logic aui_coll_i,
  input wire logic mgmt_attached_i,
  input wire logic test_pin_i,
  input wire logic mgmt_clk_i,
  input wire logic mgmt_data_i,
  input wire logic aui_di_i,
  input wire logic aui_di_squelch_ok_i,
  input wire logic [NUM_TP-1:0] tp_rxd_i,
  input wire logic [NUM_TP-1:0] tp_squelch_ok_i,
  input wire logic aui_do_norm_i,
  input wire logic [NUM_TP-1:0] tp_txd_norm_i,
  input wire logic [NUM_TP-1:0] tp_txp_norm_i,
  output logic activity_serial_out_o,
  output logic activity_frame_strobe_o,
  output logic activity_frame_strobe_oe_o,
  output logic loopback_o,
  output logic min_mode_o,
  output logic aui_do_o,
  output logic [NUM_TP-1:0] tp_txd_o,
  output logic [NUM_TP-1:0] tp_predistort_pair_o
);
  // =====================================================
  // input synchronisers
  localparam int NS = NUM_TP + 6;
  logic [NS-1:0] raw_w;
  logic [NS-1:0] syn_w;
  assign raw_w = {tp_crs_i, aui_crs_i, aui_coll_i, mgmt_attached_i, test_pin_i,
                  mgmt_clk_i, mgmt_data_i};
  palc_sync #(.W(NS)) u_sync (
    .clock_i(clock_i),
    .async_i(raw_w),
    .sync_o(syn_w)
  );
  logic [NUM_TP-1:0] tp_crs_s;
  logic aui_crs_s, coll_s, attached_s, test_s, mclk_s, mdat_s;
  assign {tp_crs_s, aui_crs_s, coll_s, attached_s, test_s, mclk_s, mdat_s} = syn_w;

  // =====================================================
  // slot and sample timing
  logic [7:0] slot_cnt_q;
  logic [3:0] slot_q;
  logic slot_end;
  logic frame_end;
  assign slot_end = (slot_cnt_q == SLOT_CYC_LAST);
  assign frame_end = slot_end && (slot_q == SLOT_LAST);
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      slot_cnt_q <= '0;
      slot_q <= SLOT_COLL;
    end else if (slot_end) begin
      slot_cnt_q <= '0;
      slot_q <= frame_end ? SLOT_COLL : slot_q + 4'h1;
    end else begin
      slot_cnt_q <= slot_cnt_q + 8'h01;
    end
  end

  // =====================================================
  // activity capture: sticky over the period, snapshot at its end
  logic [NUM_TP:0] sticky_q;
  logic [NUM_TP:0] snap_q;
  logic [NUM_TP:0] crs_now;
  assign crs_now = {tp_crs_s, aui_crs_s};
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sticky_q <= '0;
      snap_q <= '0;
    end else if (frame_end) begin
      snap_q <= sticky_q | crs_now;
      sticky_q <= crs_now;
    end else begin
      sticky_q <= sticky_q | crs_now;
    end
  end

  // =====================================================
  // serial stream out
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      activity_serial_out_o <= 1'b0;
      activity_frame_strobe_o <= 1'b0;
      activity_frame_strobe_oe_o <= 1'b0;
    end else begin
      if (slot_q == SLOT_COLL) begin
        activity_serial_out_o <= attached_s ? coll_s : 1'b0;
      end else begin
        activity_serial_out_o <= snap_q[slot_q - SLOT_AUI];
      end
      activity_frame_strobe_o <= (slot_q == SLOT_COLL) && !attached_s;
      activity_frame_strobe_oe_o <= !attached_s;
    end
  end

  // =====================================================
  // mode select and loopback programming
  typedef enum logic [1:0] {PALC_RESET, PALC_NORMAL, PALC_MIN} palc_mode_e;
  palc_mode_e mode_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode_q <= PALC_RESET;
    end else begin
      case (mode_q)
        PALC_RESET: mode_q <= test_s ? PALC_MIN : PALC_NORMAL;
        PALC_NORMAL: mode_q <= PALC_NORMAL;
        PALC_MIN: mode_q <= PALC_MIN;
        default: mode_q <= PALC_RESET;
      endcase
    end
  end
  // strap caught at the first edge after release; test pin seen through sync
  assign min_mode_o = (mode_q == PALC_MIN);

  logic mclk_d1_q;
  logic mclk_rise;
  logic [1:0] zeros_q;
  logic loop_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mclk_d1_q <= 1'b0;
    end else begin
      mclk_d1_q <= mclk_s;
    end
  end
  assign mclk_rise = mclk_s && !mclk_d1_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !test_s || mode_q != PALC_NORMAL) begin
      zeros_q <= '0;
      loop_q <= 1'b0;
    end else if (mclk_rise) begin
      if (mdat_s) begin
        zeros_q <= '0;
      end else if (zeros_q != ZEROS_TO_LOOP) begin
        zeros_q <= zeros_q + 2'h1;
        if (zeros_q + 2'h1 == ZEROS_TO_LOOP) begin
          loop_q <= 1'b1;
        end
      end
    end
  end
  assign loopback_o = loop_q;

  // =====================================================
  // transmit muxing: combinational, no retiming on the echo path
  always_comb begin
    if (loop_q) begin
      aui_do_o = aui_di_i & aui_di_squelch_ok_i;
      tp_txd_o = tp_rxd_i & tp_squelch_ok_i;
      tp_predistort_pair_o = tp_rxd_i & tp_squelch_ok_i;
    end else begin
      aui_do_o = aui_do_norm_i;
      tp_txd_o = tp_txd_norm_i;
      tp_predistort_pair_o = tp_txp_norm_i;
    end
  end

  // =====================================================
  // checks
  strobe_at_frame_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    activity_frame_strobe_o |-> $past(slot_q) == SLOT_COLL)
    else $error("strobe outside collision slot");
  strobe_absent_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $past(attached_s) |-> !activity_frame_strobe_o && !activity_frame_strobe_oe_o)
    else $error("strobe driven while attached");
  coll_standalone_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ($past(slot_q) == SLOT_COLL && !$past(attached_s)) |-> !activity_serial_out_o)
    else $error("collision slot not low standalone");
  short_event_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (aui_crs_s && !frame_end) |=> sticky_q[0])
    else $error("short activity lost");
  min_no_loop_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    min_mode_o |=> !loop_q)
    else $error("loopback in minimum mode");
  test_low_exit_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !test_s |=> !loop_q)
    else $error("loopback held with test low");
  loop_echo_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    loop_q |-> tp_txd_o == (tp_rxd_i & tp_squelch_ok_i) && tp_predistort_pair_o == tp_txd_o)
    else $error("loopback echo wrong");
  squelch_block_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (loop_q && !aui_di_squelch_ok_i) |-> !aui_do_o)
    else $error("unqualified data echoed");
  one_resets_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mclk_rise && mdat_s && test_s) |=> zeros_q == 2'h0)
    else $error("zero count not restarted");
  frame_period_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    frame_end |=> !frame_end [*8])
    else $error("sample period too short");
endmodule
`default_nettype wire

// [test/palc_sp_model.sv]
`timescale 1ns/1ps
`default_nettype none
module palc_sp_model import palc_pkg::*; (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic serial_i,
  input wire logic strobe_i,
  output logic [9:0] frame_o,
  output logic valid_o
);
  // ==========================================
  // serial to parallel capture, framed by strobe
  int cnt;
  int pos;
  logic strobe_q;
  logic [9:0] word;
  always @(posedge clock_i) begin
    // own frame count stands in for the strobe while the strobe is absent
    pos = ((strobe_i && !strobe_q) || cnt == SLOT_CYC * NUM_SLOTS) ? 0 : cnt;
    strobe_q <= strobe_i;
    valid_o <= 1'b0;
    // sample mid-slot, away from slot edges
    if (pos < SLOT_CYC * NUM_SLOTS && pos % SLOT_CYC == SLOT_CYC / 2) word[pos / SLOT_CYC] = serial_i;
    if (pos == SLOT_CYC * NUM_SLOTS - 1) begin
      frame_o <= word;
      valid_o <= 1'b1;
    end
    cnt <= sys_rst_i ? 9999 : pos + 1;
  end
endmodule
`default_nettype wire

// [test/palc_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module palc_tb_top import palc_pkg::*;;
  logic clock_i = 0, sys_rst_i = 1, aui_crs = 0, coll = 0, att = 0, test = 0, mclk = 0, mdat = 1;
  logic di = 1, di_sq = 1, do_n = 0, ser, stb, oe, lb, mm, aui_do, vld;
  logic [7:0] activity_serial_out = 0, rxd = 8'h3c, sq = 8'hf0, txd_n = 8'h5a, txp_n = 8'ha5, txd, tp_predistort_pair;
  logic [9:0] frm, acc;
  int err_total = 0, checks_done = 0;
  always #4 clock_i = ~clock_i;
  palc_top dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .tp_crs_i(activity_serial_out), .aui_crs_i(aui_crs),
    .aui_coll_i(coll), .mgmt_attached_i(att), .test_pin_i(test), .mgmt_clk_i(mclk),
    .mgmt_data_i(mdat), .aui_di_i(di), .aui_di_squelch_ok_i(di_sq), .tp_rxd_i(rxd),
    .tp_squelch_ok_i(sq), .aui_do_norm_i(do_n), .tp_txd_norm_i(txd_n), .tp_txp_norm_i(txp_n),
    .activity_serial_out_o(ser), .activity_frame_strobe_o(stb),
    .activity_frame_strobe_oe_o(oe), .loopback_o(lb), .min_mode_o(mm), .aui_do_o(aui_do),
    .tp_txd_o(txd), .tp_predistort_pair_o(tp_predistort_pair));
  palc_sp_model model_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .serial_i(ser),
    .strobe_i(stb), .frame_o(frm), .valid_o(vld));
  // ==========================================
  // helpers
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frames(input int n);
    acc = 0;
    repeat (n) begin
      @(posedge vld);
      acc = acc | frm;
    end
  endtask
  task automatic do_reset(input logic strap);
    test <= strap;
    sys_rst_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    test <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask
  task automatic shift_bit(input logic b);
    mdat <= b;
    repeat (4) @(posedge clock_i);
    mclk <= 1'b1;
    repeat (4) @(posedge clock_i);
    mclk <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask
  task automatic program_loop();
    test <= 1'b1;
    repeat (4) @(posedge clock_i);
    shift_bit(1'b0);
    shift_bit(1'b0);
    shift_bit(1'b1);
    shift_bit(1'b0);
    shift_bit(1'b0);
    chk(lb, 0);
    shift_bit(1'b0);
    repeat (4) @(posedge clock_i);
  endtask
  // ==========================================
  // scenarios
  task automatic t_activity();
    activity_serial_out <= 8'ha5;
    aui_crs <= 1'b1;
    coll <= 1'b1;
    frames(3);
    chk(frm, 10'h296);
    chk({9'h0, oe}, 10'h1);
    att <= 1'b1;
    frames(3);
    chk({9'h0, oe}, 10'h0);
    chk(frm, 10'h297);
    att <= 1'b0;
    coll <= 1'b0;
    activity_serial_out <= 8'h00;
    aui_crs <= 1'b0;
    frames(3);
    chk(frm, 10'h000);
    $display("test activity done");
  endtask
  task automatic t_short();
    activity_serial_out[3] <= 1'b1;
    repeat (3) @(posedge clock_i);
    activity_serial_out[3] <= 1'b0;
    frames(3);
    chk(acc, 10'h020);
    $display("test short pulse done");
  endtask
  task automatic t_loop();
    chk({aui_do, txd, 1'b0}, {do_n, txd_n, 1'b0});
    program_loop();
    chk({9'h0, lb}, 10'h1);
    chk({aui_do, txd, 1'b0}, 10'h260);
    chk({1'b0, tp_predistort_pair, 1'b0}, 10'h060);
    di_sq <= 1'b0;
    @(posedge clock_i);
    #1 chk({9'h0, aui_do}, 10'h0);
    test <= 1'b0;
    repeat (6) @(posedge clock_i);
    chk({lb, tp_predistort_pair, 1'b0}, {1'b0, txp_n, 1'b0});
    $display("test loopback done");
  endtask
  task automatic t_minmode();
    do_reset(1'b1);
    chk({9'h0, mm}, 10'h1);
    program_loop();
    chk({9'h0, lb}, 10'h0);
    do_reset(1'b0);
    chk({8'h0, mm, lb}, 10'h0);
    $display("test minimum mode done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    chk({8'h0, mm, lb}, 10'h0);
    t_activity();
    t_short();
    t_loop();
    t_minmode();
    wrap_up();
  end
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
